/* File: flash_security_ctl.sv */
// flash control, option loading and debug security gating
`timescale 1ns/1ps
module flash_security_ctl
    import flash_ctl_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // cpu / debug data bus
    input wire logic [13:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_from_debug,
    input wire logic bus_fetch_from_flash,
    output logic [7:0] bus_rdata,
    // flash array
    input wire logic [7:0] array_rdata,
    output logic [13:0] array_addr,
    output logic [7:0] array_wdata,
    output logic array_write,
    output logic array_erase_all,
    output logic array_hv,
    // system
    input wire logic mode_select_pin,
    input wire logic debug_pin_enable_wr,
    input wire logic debug_pin_enable_in,
    output logic debug_pin_enable,
    output logic debug_blocked,
    output logic secured,
    output logic [7:0] port_a_pull_enable_reg,
    output logic [7:0] port_a_pull_direction_reg,
    output logic [7:0] port_a_slew_enable_reg
);
    typedef enum logic [1:0] {LOAD_REQ, LOAD_WAIT, RUNNING} boot_t;

    logic ms_meta, ms_sync;
    boot_t boot, next_boot;
    logic [7:0] options_working_reg, next_options;
    logic [7:0] flash_control_reg, next_control;
    logic [7:0] page_selector, next_page;
    logic [7:0] next_pull_en, next_pull_dir, next_slew;
    logic next_dbg_pe, next_dbg_blocked;
    logic [7:0] next_rdata;
    logic in_window, flash_target, ctrl_write_ok;
    logic [13:0] eff_addr;
    flash_array_if arr();

    function automatic logic [13:0] window_map(input logic [7:0] page, input logic [13:0] a);
        window_map = {page, a[5:0]};
    endfunction

    // mode pin synchroniser, left unreset so it follows the pin while reset is held
    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            ms_meta <= mode_select_pin;
            ms_sync <= ms_meta;
        end
    end

    assign in_window = bus_addr >= WINDOW_BASE_ADDR && bus_addr <= WINDOW_LAST_ADDR;
    assign eff_addr = in_window ? window_map(page_selector, bus_addr) : bus_addr;
    assign flash_target = eff_addr >= FLASH_BASE_ADDR;
    // flash-fetched code cannot drive program or erase
    assign ctrl_write_ok = bus_wr && !bus_fetch_from_flash;
    assign secured = ~options_working_reg[SECURITY_BIT];

    assign arr.addr = eff_addr;
    assign arr.wdata = bus_wdata;
    assign arr.latch = ctrl_write_ok && in_window && flash_target;
    assign arr.byte_wr = arr.latch;
    assign arr.program_mode = flash_control_reg[PROGRAM_BIT];
    assign arr.erase_mode = flash_control_reg[ERASE_BIT];
    assign arr.hv_on = flash_control_reg[HV_BIT];

    // boot, option copy and register writes
    always_comb begin
        next_boot = boot;
        next_options = options_working_reg;
        next_control = flash_control_reg;
        next_page = page_selector;
        next_pull_en = port_a_pull_enable_reg;
        next_pull_dir = port_a_pull_direction_reg;
        next_slew = port_a_slew_enable_reg;
        next_dbg_pe = debug_pin_enable;
        next_dbg_blocked = debug_blocked;
        case (boot)
            LOAD_REQ: next_boot = LOAD_WAIT;
            LOAD_WAIT: begin
                // copy bit zero of option byte, which selects security
                next_options = {7'h00, array_rdata[SECURITY_BIT]};
                if (ms_sync && !array_rdata[SECURITY_BIT]) begin
                    next_dbg_pe = 1'b0;
                    next_dbg_blocked = 1'b1;
                end
                next_boot = RUNNING;
            end
            RUNNING: begin
                if (debug_pin_enable_wr && !debug_blocked) begin
                    next_dbg_pe = debug_pin_enable_in;
                end
                if (bus_wr && bus_addr == PAGE_SELECTOR_ADDR) begin
                    next_page = bus_wdata;
                end
                // control reachable from debug even when secured
                if (ctrl_write_ok && eff_addr == FLASH_CONTROL_ADDR) begin
                    next_control[ERASE_BIT] = bus_wdata[ERASE_BIT];
                    if (!secured) begin
                        next_control[PROGRAM_BIT] = bus_wdata[PROGRAM_BIT];
                    end
                    // selects exclusive, keep the one already set
                    if (next_control[PROGRAM_BIT] && next_control[ERASE_BIT]) begin
                        next_control[PROGRAM_BIT] = flash_control_reg[PROGRAM_BIT];
                        next_control[ERASE_BIT] = flash_control_reg[ERASE_BIT];
                    end
                    next_control[HV_BIT] = bus_wdata[HV_BIT] &&
                        (next_control[PROGRAM_BIT] || next_control[ERASE_BIT] ||
                         flash_control_reg[HV_BIT]);
                    if (!flash_control_reg[HV_BIT] && bus_wdata[HV_BIT] &&
                        !(flash_control_reg[PROGRAM_BIT] || flash_control_reg[ERASE_BIT])) begin
                        next_control[HV_BIT] = 1'b0;
                    end
                end
                if (bus_wr && eff_addr == PORT_A_PULL_ENABLE_ADDR) begin
                    next_pull_en = bus_wdata & PORT_PULL_MASK;
                end
                if (bus_wr && eff_addr == PORT_A_PULL_DIRECTION_ADDR) begin
                    next_pull_dir = bus_wdata & PORT_PULL_MASK;
                end
                if (bus_wr && eff_addr == PORT_A_SLEW_ENABLE_ADDR) begin
                    next_slew = bus_wdata & PORT_SLEW_MASK;
                end
            end
            default: next_boot = LOAD_REQ;
        endcase
    end

    // read data path
    always_comb begin
        next_rdata = 8'h00;
        if (bus_rd) begin
            if (flash_target) begin
                // secured flash reads from debug return zero
                if (!(secured && (bus_from_debug || debug_pin_enable))) begin
                    next_rdata = array_rdata;
                end
            end else if (eff_addr == OPTIONS_WORKING_ADDR) begin
                next_rdata = options_working_reg;
            end else if (eff_addr == FLASH_CONTROL_ADDR) begin
                next_rdata = flash_control_reg;
            end else if (eff_addr == PAGE_SELECTOR_ADDR) begin
                next_rdata = page_selector;
            end else if (eff_addr == PORT_A_PULL_ENABLE_ADDR) begin
                next_rdata = port_a_pull_enable_reg;
            end else if (eff_addr == PORT_A_PULL_DIRECTION_ADDR) begin
                next_rdata = port_a_pull_direction_reg;
            end else if (eff_addr == PORT_A_SLEW_ENABLE_ADDR) begin
                next_rdata = port_a_slew_enable_reg;
            end
        end
    end

    logic [13:0] arr_addr_q;

    // option byte during boot, the pending byte write, else the bus address for reads
    assign array_addr = (boot != RUNNING) ? OPTIONS_NONVOLATILE_ADDR :
        (array_write ? arr_addr_q : eff_addr);

    // state registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            boot <= LOAD_REQ;
            options_working_reg <= OPTIONS_RESET;
            flash_control_reg <= CONTROL_RESET;
            page_selector <= PAGE_RESET;
            port_a_pull_enable_reg <= PORT_RESET;
            port_a_pull_direction_reg <= PORT_RESET;
            port_a_slew_enable_reg <= PORT_RESET;
            debug_pin_enable <= 1'b0;
            debug_blocked <= 1'b0;
            bus_rdata <= 8'h00;
        end else if (clk_en) begin
            boot <= next_boot;
            options_working_reg <= next_options;
            flash_control_reg <= next_control;
            page_selector <= next_page;
            port_a_pull_enable_reg <= next_pull_en;
            port_a_pull_direction_reg <= next_pull_dir;
            port_a_slew_enable_reg <= next_slew;
            debug_pin_enable <= next_dbg_pe;
            debug_blocked <= next_dbg_blocked;
            bus_rdata <= next_rdata;
        end
    end

    flash_row_latch u_row (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .cmd(arr.port),
        .array_addr(arr_addr_q),
        .array_wdata(array_wdata),
        .array_write(array_write),
        .array_erase_all(array_erase_all),
        .array_hv(array_hv)
    );

    // checks
    property p_selects_exclusive;
        @(posedge sys_clk) disable iff (!rst_n)
        !(flash_control_reg[PROGRAM_BIT] && flash_control_reg[ERASE_BIT]);
    endproperty
    a_selects_exclusive: assert property (p_selects_exclusive)
        else $error("program and erase selected together");
    property p_hv_needs_select;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(flash_control_reg[HV_BIT]) |->
            $past(flash_control_reg[PROGRAM_BIT] || flash_control_reg[ERASE_BIT]);
    endproperty
    a_hv_needs_select: assert property (p_hv_needs_select)
        else $error("high voltage set without select");
    property p_secure_no_program;
        @(posedge sys_clk) disable iff (!rst_n)
        secured && !flash_control_reg[PROGRAM_BIT] |=> !flash_control_reg[PROGRAM_BIT];
    endproperty
    a_secure_no_program: assert property (p_secure_no_program)
        else $error("program select set while secured");
    property p_secure_read_zero;
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en && bus_rd && flash_target && secured && bus_from_debug && boot == RUNNING
            |=> bus_rdata == 8'h00;
    endproperty
    a_secure_read_zero: assert property (p_secure_read_zero)
        else $error("secured debug read leaked data");
    property p_options_upper_zero;
        @(posedge sys_clk) disable iff (!rst_n)
        options_working_reg[7:1] == 7'h00;
    endproperty
    a_options_upper_zero: assert property (p_options_upper_zero)
        else $error("options upper bits not zero");
    property p_option_copy;
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en && boot == LOAD_WAIT |=> options_working_reg[0] == $past(array_rdata[0]);
    endproperty
    a_option_copy: assert property (p_option_copy)
        else $error("option byte not copied");
    property p_options_stable;
        @(posedge sys_clk) disable iff (!rst_n)
        boot == RUNNING && $past(boot) == RUNNING |-> $stable(options_working_reg);
    endproperty
    a_options_stable: assert property (p_options_stable)
        else $error("options changed after boot");
    property p_debug_block;
        @(posedge sys_clk) disable iff (!rst_n)
        debug_blocked |-> !debug_pin_enable;
    endproperty
    a_debug_block: assert property (p_debug_block)
        else $error("debug enabled while blocked");
    c_erase_run: cover property (@(posedge sys_clk) disable iff (!rst_n) array_erase_all);
    c_secured: cover property (@(posedge sys_clk) disable iff (!rst_n) secured);
    c_blocked: cover property (@(posedge sys_clk) disable iff (!rst_n) debug_blocked);
    c_row_armed: cover property (@(posedge sys_clk) disable iff (!rst_n)
        arr.armed && arr.row_base[13:6] == page_selector);
endmodule

/* File: flash_ctl_pkg.sv */
// package holding the flash controller address map, field positions and reset values
// Behaviour
// - Flash is programmed one 64-byte row at a time, rows aligned on 64 bytes.
// - Program-select arms latching of address and data of next flash write. Here that write latches only its row address, and its data is not written.
// - Secured flash reads via debug or with debug pin enable return zero.
// - Every reset copies the nonvolatile option byte into the working register.
// - Option bit one leaves device unsecured; zero engages security after reset.
// - Security released only by bulk erase then any reset.
// - Debug keeps register and RAM access while secured, including erase control.
// - Normal-mode boot while secured clears debug pin enable, blocks debug.
// - Trim locations near flash top behave as ordinary flash.
// - High voltage only with a select bit set; both selects never together. Here high voltage stays on after both selects are cleared.
// - While secured, writes to program-select are ignored.
// - Working options register reads upper seven bits zero; writes ignored.
package flash_ctl_pkg;
    localparam logic [13:0] OPTIONS_WORKING_ADDR = 14'h0210;
    localparam logic [13:0] FLASH_CONTROL_ADDR = 14'h0211;
    localparam logic [13:0] PORT_A_PULL_ENABLE_ADDR = 14'h0220;
    localparam logic [13:0] PORT_A_PULL_DIRECTION_ADDR = 14'h0221;
    localparam logic [13:0] PORT_A_SLEW_ENABLE_ADDR = 14'h0222;
    localparam logic [13:0] OSC_TRIM_STORE_ADDR = 14'h3ffa;
    localparam logic [13:0] FINE_TRIM_STORE_ADDR = 14'h3ffb;
    localparam logic [13:0] OPTIONS_NONVOLATILE_ADDR = 14'h3ffc;
    localparam logic [13:0] FLASH_BASE_ADDR = 14'h3800;
    localparam logic [13:0] PAGE_SELECTOR_ADDR = 14'h001f;
    localparam logic [13:0] WINDOW_BASE_ADDR = 14'h00c0;
    localparam logic [13:0] WINDOW_LAST_ADDR = 14'h00ff;
    localparam int ROW_BYTES = 64;
    localparam int SECURITY_BIT = 0;
    localparam int PROGRAM_BIT = 0;
    localparam int ERASE_BIT = 2;
    localparam int HV_BIT = 3;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] OPTIONS_RESET = 8'h01;
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic [7:0] PORT_PULL_MASK = 8'h37;
    localparam logic [7:0] PORT_SLEW_MASK = 8'h3b;
    localparam logic [7:0] PAGE_RESET = 8'h00;
endpackage

/* File: flash_array_if.sv */
// interface carrying flash array commands from controller to array port logic
`timescale 1ns/1ps
interface flash_array_if;
    logic [13:0] addr;
    logic [7:0] wdata;
    logic latch;
    logic byte_wr;
    logic program_mode;
    logic erase_mode;
    logic hv_on;
    logic [13:0] row_base;
    logic armed;
    modport ctrl (output addr, wdata, latch, byte_wr, program_mode, erase_mode, hv_on,
        input row_base, armed);
    modport port (input addr, wdata, latch, byte_wr, program_mode, erase_mode, hv_on,
        output row_base, armed);
endinterface

/* File: flash_row_latch.sv */
// row latch: captures the armed row and forwards array strobes
`timescale 1ns/1ps
module flash_row_latch
    import flash_ctl_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // command side
    flash_array_if.port cmd,
    // array pins
    output logic [13:0] array_addr,
    output logic [7:0] array_wdata,
    output logic array_write,
    output logic array_erase_all,
    output logic array_hv
);
    logic [13:0] row_base;
    logic armed;
    logic [13:0] next_row_base;
    logic next_armed;
    logic [13:0] next_array_addr;
    logic [7:0] next_array_wdata;
    logic next_array_write;

    // row capture and per-byte write strobe
    always_comb begin
        next_row_base = row_base;
        next_armed = armed;
        next_array_addr = array_addr;
        next_array_wdata = array_wdata;
        next_array_write = 1'b0;
        if (!cmd.program_mode && !cmd.erase_mode) begin
            next_armed = 1'b0;
        end else if (cmd.latch && !armed) begin
            next_row_base = {cmd.addr[13:6], 6'h00};
            next_armed = 1'b1;
        end else if (cmd.byte_wr && armed && cmd.program_mode && cmd.hv_on
                     && cmd.addr[13:6] == row_base[13:6]) begin
            next_array_addr = cmd.addr;
            next_array_wdata = cmd.wdata;
            next_array_write = 1'b1;
        end
    end

    // registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            row_base <= 14'h0000;
            armed <= 1'b0;
            array_addr <= 14'h0000;
            array_wdata <= 8'h00;
            array_write <= 1'b0;
        end else if (clk_en) begin
            row_base <= next_row_base;
            armed <= next_armed;
            array_addr <= next_array_addr;
            array_wdata <= next_array_wdata;
            array_write <= next_array_write;
        end
    end

    assign cmd.row_base = row_base;
    assign cmd.armed = armed;
    assign array_erase_all = armed & cmd.erase_mode & cmd.hv_on;
    assign array_hv = cmd.hv_on;

    property p_write_in_row;
        @(posedge sys_clk) disable iff (!rst_n)
        array_write |-> array_addr[13:6] == row_base[13:6];
    endproperty
    a_write_in_row: assert property (p_write_in_row)
        else $error("byte write outside latched row");
    c_row_write: cover property (@(posedge sys_clk) disable iff (!rst_n) array_write);
endmodule

/* File: flash_array_model.sv */
// behavioural flash array answering the controller's array port
`timescale 1ns/1ps
module flash_array_model (
    // clock
    input wire logic sys_clk,
    // array port
    input wire logic [13:0] array_addr,
    input wire logic [7:0] array_wdata,
    input wire logic array_write,
    input wire logic array_erase_all,
    output logic [7:0] array_rdata
);
    logic [7:0] mem [0:16383];
    // array starts erased, so the option byte reads unsecured
    initial begin
        foreach (mem[i]) mem[i] = 8'hff;
    end
    assign array_rdata = mem[array_addr];
    // programming only clears bits, bulk erase restores ones
    always @(posedge sys_clk) begin
        if (array_erase_all) begin
            foreach (mem[i]) mem[i] <= 8'hff;
        end else if (array_write) begin
            mem[array_addr] <= mem[array_addr] & array_wdata;
        end
    end
endmodule

/* File: flash_security_ctl_tb.sv */
// self-checking bench for the flash control and security block
`timescale 1ns/1ps
module flash_security_ctl_tb;
    import flash_ctl_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [13:0] bus_addr = 14'h0000;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic bus_from_debug = 1'b0;
    logic bus_fetch_from_flash = 1'b0;
    logic mode_select_pin = 1'b0;
    logic debug_pin_enable_wr = 1'b0;
    logic debug_pin_enable_in = 1'b0;
    logic [7:0] bus_rdata, array_rdata, array_wdata, rd_val, wd;
    logic [13:0] array_addr;
    logic array_write, array_erase_all, array_hv, debug_pin_enable, debug_blocked, secured;
    logic [7:0] pv [3];
    logic [7:0] pull_en, pull_dir, slew_en;
    integer err_total = 0;
    integer cmp_count = 0;
    integer seed = 33;

    flash_security_ctl u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_from_debug(bus_from_debug), .bus_fetch_from_flash(bus_fetch_from_flash),
        .bus_rdata(bus_rdata), .array_rdata(array_rdata), .array_addr(array_addr),
        .array_wdata(array_wdata), .array_write(array_write),
        .array_erase_all(array_erase_all), .array_hv(array_hv),
        .mode_select_pin(mode_select_pin), .debug_pin_enable_wr(debug_pin_enable_wr),
        .debug_pin_enable_in(debug_pin_enable_in), .debug_pin_enable(debug_pin_enable),
        .debug_blocked(debug_blocked), .secured(secured),
        .port_a_pull_enable_reg(pull_en), .port_a_pull_direction_reg(pull_dir),
        .port_a_slew_enable_reg(slew_en));

    flash_array_model u_array (.sys_clk(sys_clk), .array_addr(array_addr),
        .array_wdata(array_wdata), .array_write(array_write),
        .array_erase_all(array_erase_all), .array_rdata(array_rdata));

    // 20 MHz system clock
    always #25 sys_clk = ~sys_clk;

    // flash address seen through the paging window
    function automatic logic [13:0] flash_addr(input logic [7:0] pg, input int off);
        return {pg, 6'(off)};
    endfunction

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask

    // mode pin settles well before reset ends, then boot load runs
    task automatic do_reset(input logic mode);
        mode_select_pin <= mode;
        rst_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask

    // request stands over one sampling edge; results are read at the edge after
    task automatic bus_write(input logic [13:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic reg_chk(input logic [13:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        @(posedge sys_clk);
        rd_val = bus_rdata;
        chk(rd_val, exp);
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // watchdog well beyond the fewer than 200 cycles the tests need
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        final_report;
    end

    initial begin
        do_reset(1'b0);
        reg_chk(OPTIONS_WORKING_ADDR, 8'h01);
        chk(secured, 1'b0);
        bus_write(OPTIONS_WORKING_ADDR, 8'hfe);
        reg_chk(OPTIONS_WORKING_ADDR, 8'h01);
        // clock enable held low freezes state, so this page write is lost
        clk_en <= 1'b0;
        bus_write(PAGE_SELECTOR_ADDR, 8'h55);
        clk_en <= 1'b1;
        reg_chk(PAGE_SELECTOR_ADDR, PAGE_RESET);
        // port registers take random data through their masks
        for (int i = 0; i < 3; i++) begin
            pv[i] = 8'($random(seed));
            bus_write(PORT_A_PULL_ENABLE_ADDR + 14'(i), pv[i]);
        end
        chk({pull_en, pull_dir, slew_en},
            {pv[0] & PORT_PULL_MASK, pv[1] & PORT_PULL_MASK, pv[2] & PORT_SLEW_MASK});
        // interlocks on the control register
        bus_write(FLASH_CONTROL_ADDR, 8'h08);
        reg_chk(FLASH_CONTROL_ADDR, 8'h00);
        @(posedge sys_clk);
        bus_fetch_from_flash <= 1'b1;
        bus_write(FLASH_CONTROL_ADDR, 8'h01);
        bus_fetch_from_flash <= 1'b0;
        reg_chk(FLASH_CONTROL_ADDR, 8'h00);
        bus_write(FLASH_CONTROL_ADDR, 8'h01);
        bus_write(FLASH_CONTROL_ADDR, 8'h05);
        reg_chk(FLASH_CONTROL_ADDR, 8'h01);
        // map the row, latch it, raise high voltage, program bytes
        bus_write(PAGE_SELECTOR_ADDR, 8'he0);
        bus_write(WINDOW_BASE_ADDR + 14'h05, 8'h00);
        chk(array_write, 1'b0);
        bus_write(FLASH_CONTROL_ADDR, 8'h09);
        chk(array_hv, 1'b1);
        for (int k = 0; k < ROW_BYTES; k += 21) begin
            wd = 8'($random(seed));
            bus_write(WINDOW_BASE_ADDR + 14'(k), wd);
            chk({array_write, array_addr, array_wdata}, {1'b1, flash_addr(8'he0, k), wd});
        end
        bus_write(PAGE_SELECTOR_ADDR, 8'he1);
        bus_write(WINDOW_BASE_ADDR, 8'h00);
        chk(array_write, 1'b0);
        // drop select first, then high voltage
        bus_write(FLASH_CONTROL_ADDR, 8'h08);
        bus_write(FLASH_CONTROL_ADDR, 8'h00);
        chk(array_hv, 1'b0);
        // unsecured read returns the last programmed byte of the row
        bus_write(PAGE_SELECTOR_ADDR, 8'he0);
        reg_chk(WINDOW_BASE_ADDR + 14'h3f, wd);
        // program bit zero of the option byte to zero, engaging security
        bus_write(PAGE_SELECTOR_ADDR, 8'hff);
        bus_write(FLASH_CONTROL_ADDR, 8'h01);
        bus_write(WINDOW_BASE_ADDR + 14'h3c, 8'h00);
        bus_write(FLASH_CONTROL_ADDR, 8'h09);
        bus_write(WINDOW_BASE_ADDR + 14'h3c, 8'hfe);
        chk(array_addr, OPTIONS_NONVOLATILE_ADDR);
        bus_write(FLASH_CONTROL_ADDR, 8'h08);
        bus_write(FLASH_CONTROL_ADDR, 8'h00);
        do_reset(1'b1);
        chk({secured, debug_pin_enable, debug_blocked}, 3'b101);
        reg_chk(OPTIONS_WORKING_ADDR, 8'h00);
        bus_write(FLASH_CONTROL_ADDR, 8'h01);
        reg_chk(FLASH_CONTROL_ADDR, 8'h00);
        // debug pin enable set: flash reads come back empty
        do_reset(1'b0);
        chk(debug_blocked, 1'b0);
        @(posedge sys_clk);
        debug_pin_enable_wr <= 1'b1;
        debug_pin_enable_in <= 1'b1;
        @(posedge sys_clk);
        debug_pin_enable_wr <= 1'b0;
        bus_write(PAGE_SELECTOR_ADDR, 8'he0);
        reg_chk(WINDOW_BASE_ADDR, 8'h00);
        // bulk erase driven from the debug side
        @(posedge sys_clk);
        bus_from_debug <= 1'b1;
        reg_chk(WINDOW_BASE_ADDR + 14'h01, 8'h00);
        bus_write(FLASH_CONTROL_ADDR, 8'h04);
        reg_chk(FLASH_CONTROL_ADDR, 8'h04);
        bus_write(WINDOW_BASE_ADDR, 8'h00);
        bus_write(FLASH_CONTROL_ADDR, 8'h0c);
        chk({array_erase_all, array_hv}, 2'b11);
        bus_write(FLASH_CONTROL_ADDR, 8'h08);
        bus_write(FLASH_CONTROL_ADDR, 8'h00);
        chk({array_erase_all, array_hv}, 2'b00);
        bus_from_debug <= 1'b0;
        do_reset(1'b1);
        chk({secured, debug_blocked}, 2'b00);
        reg_chk(OPTIONS_WORKING_ADDR, 8'h01);
        final_report;
    end
endmodule
